//--- src/dbg_id_pkg.sv
// constants, field layouts and carrier types for the debug identity register bank
// assumes a 32-bit byte-addressed register bus reaching a 4 KB window
package dbg_id_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_PERMISSION = 12'hFB8;
   localparam logic [11:0] OFS_CAPABILITY = 12'hFC8;
   localparam logic [11:0] OFS_CAP_EXT_ONE = 12'hFC4;
   localparam logic [11:0] OFS_CAP_EXT_TWO = 12'hFC0;
   localparam logic [11:0] OFS_ARCH_ID = 12'hFBC;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_W = 12;
   // ------------------------------------------------------------
   // permission field encodings and positions
   // ------------------------------------------------------------
   localparam logic [1:0] PERM_ABSENT = 2'h0;
   localparam logic [1:0] PERM_DISABLED = 2'h2;
   localparam logic [1:0] PERM_ENABLED = 2'h3;
   localparam int POS_SEC_NONINV = 6;
   localparam int POS_SEC_INV = 4;
   localparam int POS_NS_NONINV = 2;
   localparam int POS_NS_INV = 0;
   // ------------------------------------------------------------
   // architecture identification layout
   // ------------------------------------------------------------
   localparam int POS_ARCHITECT = 21;
   localparam int POS_PRESENT = 20;
   localparam int POS_REVISION = 16;
   localparam int POS_CONTINUATION = 28;
   // ------------------------------------------------------------
   // reset values and bus encodings
   // ------------------------------------------------------------
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   localparam logic [7:0] RST_PERM = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic secure_invasive_enable_input;
      logic secure_non_invasive_enable_input;
      logic debug_enable_input;
      logic non_invasive_enable_input;
   } dbg_enables_t;

   typedef struct packed {
      logic sec_noninv;
      logic sec_inv;
      logic ns_noninv;
      logic ns_inv;
   } dbg_support_t;

   typedef struct packed {
      logic [1:0] secure_noninvasive_status;
      logic [1:0] secure_invasive_status;
      logic [1:0] nonsecure_noninvasive_status;
      logic [1:0] nonsecure_invasive_status;
   } perm_status_t;
endpackage

//--- src/dbg_identity_regs.sv
// top of the debug identity register bank: ahb-lite slave with read-only words
// assumes a single ahb-lite master, word transfers, hready driven by this slave
`timescale 1ns/1ps
// Overview of operation
// - capability word readable at 0xFC8
// - unused capability bits read zero
// - capability shows built configuration
// - two extension capability words, free reads
// - permission word at 0xFB8, upper bits zero
// - four two-bit permission fields placed
// - field codes absent, disabled, enabled
// - unsupported level always reads zero code
// - secure invasive needs both enables
// - nonsecure invasive follows debug enable
// - secure noninvasive combined enable equation
// - nonsecure noninvasive needs either enable
// - permission changes reflected one cycle later
// - architecture word field layout
// - presence flag clear makes word zero
// - architect holds continuation and identity codes
module dbg_identity_regs import dbg_id_pkg::*; #(
   parameter logic [31:0] CAPABILITY_VAL = 32'h0000_0000,
   parameter logic [31:0] CAPABILITY_USED = 32'h0000_00FF,
   parameter logic [31:0] CAP_EXT_ONE_VAL = 32'h0000_0000,
   parameter logic [31:0] CAP_EXT_TWO_VAL = 32'h0000_0000,
   // arbitrary architect codes
   parameter logic [3:0] ARCH_CONTINUATION = 4'h1,
   parameter logic [6:0] ARCH_IDENTITY = 7'h2A,
   parameter logic ARCH_PRESENT = 1'b1,
   parameter logic [3:0] ARCH_REVISION = 4'h0,
   parameter logic [15:0] ARCHITECTURE_NUMBER = 16'h0001
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire dbg_enables_t enables_in,
   input wire dbg_support_t support_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out
);
   // ------------------------------------------------------------
   // permission fields
   // ------------------------------------------------------------
   perm_status_t perm;
   dbg_perm_status u_perm (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .enables_in(enables_in),
      .support_in(support_in),
      .status_out(perm)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [31:0] arch_word;
   assign arch_word = ARCH_PRESENT ? {ARCH_CONTINUATION, ARCH_IDENTITY, 1'b1, ARCH_REVISION,
      ARCHITECTURE_NUMBER} : 32'h0000_0000;

   function automatic logic [31:0] read_word(input logic [11:0] ofs, input perm_status_t p,
         input logic [31:0] arch);
      case (ofs)
         OFS_CAPABILITY: read_word = CAPABILITY_VAL & CAPABILITY_USED;
         OFS_CAP_EXT_ONE: read_word = CAP_EXT_ONE_VAL;
         OFS_CAP_EXT_TWO: read_word = CAP_EXT_TWO_VAL;
         OFS_PERMISSION: read_word = {24'h00_0000, p};
         OFS_ARCH_ID: read_word = arch;
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   logic rd_req;
   assign rd_req = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && !hwrite_in;

   // ------------------------------------------------------------
   // bus answer: zero wait, always okay, writes dropped
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hrdata_out <= RST_RDATA;
      end else if (rd_req) begin
         hrdata_out <= read_word(haddr_in[11:0], perm, arch_word);
      end else begin
         hrdata_out <= RST_RDATA;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hreadyout_out <= 1'b0;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   property p_perm_read;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      rd_req && haddr_in[11:0] == OFS_PERMISSION |=> hrdata_out == {24'h00_0000, $past(perm)};
   endproperty
   a_perm_read: assert property (p_perm_read) else $error("permission read wrong");
   property p_cap_read;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      rd_req && haddr_in[11:0] == OFS_CAPABILITY |=> (hrdata_out & ~CAPABILITY_USED) == 32'h0000_0000;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("unused capability bits set");
   property p_arch_read;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      rd_req && haddr_in[11:0] == OFS_ARCH_ID |=> hrdata_out[20] == ARCH_PRESENT &&
      (ARCH_PRESENT || hrdata_out == 32'h0000_0000);
   endproperty
   a_arch_read: assert property (p_arch_read) else $error("architecture word wrong");
   property p_write_quiet;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      hsel_in && hwrite_in |=> hrdata_out == 32'h0000_0000 ##1 hreadyout_out;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("write had an effect");
endmodule

//--- src/dbg_perm_status.sv
// derives the four permission fields from the enable inputs each cycle
// assumes enables are synchronous to clk_sys_in
`timescale 1ns/1ps
module dbg_perm_status import dbg_id_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire dbg_enables_t enables_in,
   input wire dbg_support_t support_in,
   output perm_status_t status_out
);
   function automatic logic [1:0] encode(input logic supported, input logic enabled);
      if (!supported) begin
         encode = PERM_ABSENT;
      end else if (enabled) begin
         encode = PERM_ENABLED;
      end else begin
         encode = PERM_DISABLED;
      end
   endfunction

   logic sid_en;
   logic nonsecure_invasive_status_en;
   logic secure_noninvasive_status_en;
   logic nonsecure_noninvasive_status_en;
   assign sid_en = enables_in.secure_invasive_enable_input & enables_in.debug_enable_input;
   assign nonsecure_invasive_status_en = enables_in.debug_enable_input;
   assign secure_noninvasive_status_en = (enables_in.secure_non_invasive_enable_input | sid_en) &
      (enables_in.non_invasive_enable_input | enables_in.debug_enable_input);
   assign nonsecure_noninvasive_status_en = enables_in.non_invasive_enable_input | enables_in.debug_enable_input;

   // resampled every cycle so a read sees the present state
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_out <= RST_PERM;
      end else begin
         status_out.secure_invasive_status <= encode(support_in.sec_inv, sid_en);
         status_out.nonsecure_invasive_status <= encode(support_in.ns_inv, nonsecure_invasive_status_en);
         status_out.secure_noninvasive_status <= encode(support_in.sec_noninv, secure_noninvasive_status_en);
         status_out.nonsecure_noninvasive_status <= encode(support_in.ns_noninv, nonsecure_noninvasive_status_en);
      end
   end

   property p_sid;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      support_in.sec_inv && sid_en |=> status_out.secure_invasive_status == 2'h3;
   endproperty
   a_sid: assert property (p_sid) else $error("secure invasive not enabled");
   property p_nonsecure_invasive_status;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      support_in.ns_inv && !enables_in.debug_enable_input |=> status_out.nonsecure_invasive_status == 2'h2;
   endproperty
   a_nonsecure_invasive_status: assert property (p_nonsecure_invasive_status) else $error("nonsecure invasive not disabled");
   property p_secure_noninvasive_status;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      support_in.sec_noninv |=> status_out.secure_noninvasive_status == {1'b1, $past(secure_noninvasive_status_en)};
   endproperty
   a_secure_noninvasive_status: assert property (p_secure_noninvasive_status) else $error("secure noninvasive wrong");
   property p_nonsecure_noninvasive_status;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      support_in.ns_noninv && !enables_in.non_invasive_enable_input && enables_in.debug_enable_input
      |=> status_out.nonsecure_noninvasive_status == 2'h3;
   endproperty
   a_nonsecure_noninvasive_status: assert property (p_nonsecure_noninvasive_status) else $error("nonsecure noninvasive wrong");
   property p_absent;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !support_in.sec_inv |=> status_out.secure_invasive_status == 2'h0;
   endproperty
   a_absent: assert property (p_absent) else $error("unsupported level not zero");
   property p_no_reserved;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      ##1 (status_out.secure_invasive_status != 2'h1 && status_out.nonsecure_invasive_status != 2'h1 &&
      status_out.secure_noninvasive_status != 2'h1 && status_out.nonsecure_noninvasive_status != 2'h1);
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved code reported");
endmodule

//--- verif/ahb_master_model.sv
// single ahb-lite master issuing whole-word transfers to one slave
// assumes hready is the slave's hreadyout and the bench top is tb_top
`timescale 1ns/1ps
module ahb_master_model import dbg_id_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   initial begin
      hsel_out = 1'h0;
      haddr_out = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'h0;
      hsize_out = HSIZE_WORD;
      hwdata_out = 32'h0;
   end
   // ------------------------------------------------------------
   // waits for hready high at a rising edge, bounded
   // ------------------------------------------------------------
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk_sys_in);
      while (hready_in !== 1'h1 && n < 50) begin
         n++;
         @(posedge clk_sys_in);
      end
      if (n >= 50) begin
         tb_top.mismatches++;
         $display("unexpected hready expected 1 seen timeout");
         tb_top.final_report();
      end
   endtask
   // address phase held until taken, then data phase; read data taken at its end
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      hsel_out <= 1'h1;
      haddr_out <= a;
      hwrite_out <= w;
      hsize_out <= HSIZE_WORD;
      htrans_out <= HTRANS_NONSEQ;
      wait_ready();
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      wait_ready();
      rd = hrdata_in;
      hwdata_out <= ~wd;
   endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the debug identity register bank
// assumes zero-wait reads with permission fields one cycle behind the enables
`timescale 1ns/1ps
module tb_top import dbg_id_pkg::*;;
   logic clk_sys_in, sys_rst_in, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] en_v, sup_v;
   int mismatches = 0;
   int checks = 0;
   logic [31:0] adr [5] = '{32'hFC8, 32'hFC4, 32'hFC0, 32'hFBC, 32'hF00};
   logic [31:0] exp [5] = '{32'h0000_0078, 32'hA5A5_0001, 32'h0F0F_0002, {4'h1, 7'h2A, 1'h1, 4'h3, 16'h0ABC}, 32'h0};
   logic [3:0] sups [3] = '{4'hF, 4'h5, 4'hA};
   initial begin
      clk_sys_in = 1'h0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   ahb_master_model u_master (.clk_sys_in(clk_sys_in), .hready_in(hreadyout), .hrdata_in(hrdata),
      .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata));
   dbg_identity_regs #(.CAPABILITY_VAL(32'h1234_5678), .CAP_EXT_ONE_VAL(32'hA5A5_0001),
      .CAP_EXT_TWO_VAL(32'h0F0F_0002), .ARCH_REVISION(4'h3), .ARCHITECTURE_NUMBER(16'h0ABC))
   u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
      .enables_in(dbg_enables_t'(en_v)), .support_in(dbg_support_t'(sup_v)), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(hresp));
   // ------------------------------------------------------------
   // expected permission word from enables and support
   // ------------------------------------------------------------
   function automatic logic [31:0] perm_exp(input logic [3:0] e, input logic [3:0] s);
      logic si, sn, d, n;
      logic [3:0] on;
      {si, sn, d, n} = e;
      on = {(sn | (si & d)) & (n | d), si & d, n | d, d};
      perm_exp = 32'h0;
      for (int i = 0; i < 4; i++) begin
         perm_exp[2*i +: 2] = s[i] ? {1'h1, on[i]} : 2'h0;
      end
   endfunction
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst_in = 1'h1;
      en_v = 4'h0;
      sup_v = 4'hF;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'h0;
      repeat (2) @(posedge clk_sys_in);
      // identity words back to back, unmapped place reads zero
      for (int i = 0; i < 5; i++) begin
         u_master.xfer(adr[i], 1'h0, 32'h0, rd);
         chk("ident word", exp[i], rd);
      end
      // writes to the identity words and the unmapped place are dropped
      for (int i = 0; i < 5; i++) begin
         u_master.xfer(adr[i], 1'h1, 32'hFFFF_FFFF, rd);
         u_master.xfer(adr[i], 1'h0, 32'h0, rd);
         chk("after write", exp[i], rd);
      end
      u_master.xfer(32'hFB8, 1'h1, 32'hFFFF_FFFF, rd);
      chk("write response", 32'h0, {31'h0, hresp});
      // every enable combination under full and partial support
      for (int s = 0; s < 3; s++) begin
         for (int e = 0; e < 16; e++) begin
            en_v <= e[3:0];
            sup_v <= sups[s];
            repeat (2) @(posedge clk_sys_in);
            u_master.xfer(32'hFB8, 1'h0, 32'h0, rd);
            chk("permission", perm_exp(e[3:0], sups[s]), rd);
         end
      end
      final_report();
   end
endmodule
